// file: src/temp_sensor_i2c.sv
`timescale 1ns/1ps
module temp_sensor_i2c #(
  parameter int RESET_CYCLES = temp_sensor_pkg::RESET_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic [15:0] temp_sample,
  input wire logic temp_sample_valid,
  output logic alarm_oe,
  output logic critical_output_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Link clock domain: serial data shifted in on rising serial clock

  logic [7:0] link_shift_r;

  always_ff @(posedge scl) begin
    link_shift_r <= {link_shift_r[6:0], sda_in};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] scl_sy_r;
  logic [2:0] sda_sy_r;
  logic [1:0] sel0_sy_r;
  logic [1:0] sel1_sy_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      scl_sy_r <= 3'h7;
      sda_sy_r <= 3'h7;
      sel0_sy_r <= 2'h0;
      sel1_sy_r <= 2'h0;
    end else begin
      scl_sy_r <= {scl_sy_r[1:0], scl};
      sda_sy_r <= {sda_sy_r[1:0], sda_in};
      sel0_sy_r <= {sel0_sy_r[0], addr_select_bit0};
      sel1_sy_r <= {sel1_sy_r[0], addr_select_bit1};
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [6:0] own_addr;

  assign scl_rise = scl_sy_r[1] & ~scl_sy_r[2];
  assign scl_fall = ~scl_sy_r[1] & scl_sy_r[2];
  assign bus_start = scl_sy_r[1] & scl_sy_r[2] & sda_sy_r[2] & ~sda_sy_r[1];
  assign bus_stop = scl_sy_r[1] & scl_sy_r[2] & ~sda_sy_r[2] & sda_sy_r[1];
  assign own_addr = {temp_sensor_pkg::BUS_ADDR_FIXED, sel1_sy_r[1], sel0_sy_r[1]};

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  temp_sensor_pkg::config_t cfg_r;
  temp_sensor_pkg::limit_flags_t flags_r;
  logic [15:0] temp_r;
  logic [15:0] high_r;
  logic [15:0] low_r;
  logic [15:0] crit_r;
  logic [3:0] hyst_r;
  logic [7:0] ptr_r;
  logic soft_rst_r;
  logic wr_en_r;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic rd_done_r;
  logic [$clog2(RESET_CYCLES+1)-1:0] busy_cnt_r;
  logic dev_busy;
  logic init;

  assign dev_busy = (busy_cnt_r != '0);
  assign init = srst | soft_rst_r;

  // Byte view of the register map, shared by first and later data bytes
  function automatic logic [7:0] reg_byte(input logic [7:0] addr);
    logic [7:0] status;
    status = 8'h00;
    status[temp_sensor_pkg::STAT_HIGH_BIT] = flags_r.over;
    status[temp_sensor_pkg::STAT_LOW_BIT] = flags_r.under;
    status[temp_sensor_pkg::STAT_CRIT_BIT] = flags_r.crit;
    case (addr)
      temp_sensor_pkg::ADDR_TEMP_MSB: reg_byte = temp_r[15:8];
      temp_sensor_pkg::ADDR_TEMP_LSB: reg_byte = temp_r[7:0];
      temp_sensor_pkg::ADDR_STATUS: reg_byte = status;
      temp_sensor_pkg::ADDR_CONFIG: reg_byte = cfg_r;
      temp_sensor_pkg::ADDR_HIGH_MSB: reg_byte = high_r[15:8];
      temp_sensor_pkg::ADDR_HIGH_LSB: reg_byte = high_r[7:0];
      temp_sensor_pkg::ADDR_LOW_MSB: reg_byte = low_r[15:8];
      temp_sensor_pkg::ADDR_LOW_LSB: reg_byte = low_r[7:0];
      temp_sensor_pkg::ADDR_CRIT_MSB: reg_byte = crit_r[15:8];
      temp_sensor_pkg::ADDR_CRIT_LSB: reg_byte = crit_r[7:0];
      temp_sensor_pkg::ADDR_HYST: reg_byte = {4'h0, hyst_r};
      temp_sensor_pkg::ADDR_ID: reg_byte = temp_sensor_pkg::ID_VALUE;
      default: reg_byte = 8'h00;
    endcase
  endfunction

  // True for the MSB address of a 16-bit pair
  function automatic logic is_pair_msb(input logic [7:0] addr);
    is_pair_msb = (addr == temp_sensor_pkg::ADDR_TEMP_MSB) || (addr == temp_sensor_pkg::ADDR_HIGH_MSB) ||
                  (addr == temp_sensor_pkg::ADDR_LOW_MSB) || (addr == temp_sensor_pkg::ADDR_CRIT_MSB);
  endfunction

  always_ff @(posedge clk) begin
    if (init) begin
      cfg_r <= temp_sensor_pkg::DEF_CONFIG;
      high_r <= temp_sensor_pkg::DEF_HIGH;
      low_r <= temp_sensor_pkg::DEF_LOW;
      crit_r <= temp_sensor_pkg::DEF_CRIT;
      hyst_r <= temp_sensor_pkg::DEF_HYST;
    end else if (wr_en_r) begin
      case (wr_addr_r)
        temp_sensor_pkg::ADDR_CONFIG: cfg_r <= wr_data_r;
        temp_sensor_pkg::ADDR_HIGH_MSB: high_r[15:8] <= wr_data_r;
        temp_sensor_pkg::ADDR_HIGH_LSB: high_r[7:0] <= wr_data_r;
        temp_sensor_pkg::ADDR_LOW_MSB: low_r[15:8] <= wr_data_r;
        temp_sensor_pkg::ADDR_LOW_LSB: low_r[7:0] <= wr_data_r;
        temp_sensor_pkg::ADDR_CRIT_MSB: crit_r[15:8] <= wr_data_r;
        temp_sensor_pkg::ADDR_CRIT_LSB: crit_r[7:0] <= wr_data_r;
        temp_sensor_pkg::ADDR_HYST: hyst_r <= wr_data_r[3:0];
        default: ;
      endcase
    end
  end

  // Conversion result keeps arriving without commands unless shut down
  always_ff @(posedge clk) begin
    if (init) begin
      temp_r <= temp_sensor_pkg::DEF_TEMP;
    end else if (temp_sample_valid && cfg_r.op_mode != temp_sensor_pkg::OP_SHUTDOWN) begin
      temp_r <= temp_sample;
    end
  end

  // Reload window: bus is ignored until the count runs out
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_cnt_r <= '0;
    end else if (soft_rst_r) begin
      busy_cnt_r <= ($clog2(RESET_CYCLES+1))'(RESET_CYCLES);
    end else if (dev_busy) begin
      busy_cnt_r <= busy_cnt_r - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus protocol engine

  temp_sensor_pkg::bus_state_t state_r;
  logic [3:0] bitcnt_r;
  logic [7:0] rx_byte_r;
  logic [7:0] tx_byte_r;
  logic [1:0] byte_no_r;
  logic dev_ack_r;
  logic gc_r;
  logic gc_rst_pend_r;
  logic ptr_rst_pend_r;
  logic [7:0] wr_target;

  assign wr_target = ptr_r + 8'(byte_no_r) - 8'h01;

  always_ff @(posedge clk) begin
    if (init) begin
      state_r <= temp_sensor_pkg::S_IDLE;
      bitcnt_r <= 4'h0;
      rx_byte_r <= 8'h00;
      tx_byte_r <= 8'h00;
      byte_no_r <= 2'h0;
      dev_ack_r <= 1'b0;
      gc_r <= 1'b0;
      gc_rst_pend_r <= 1'b0;
      ptr_rst_pend_r <= 1'b0;
      ptr_r <= temp_sensor_pkg::DEF_PTR;
      sda_oe <= 1'b0;
      soft_rst_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
      rd_done_r <= 1'b0;
    end else begin
      wr_en_r <= 1'b0;
      rd_done_r <= 1'b0;
      if (bus_stop) begin
        // Pointer reset command counts only with no data byte after it
        if (state_r == temp_sensor_pkg::S_WRITE && ptr_rst_pend_r) begin
          soft_rst_r <= 1'b1;
        end
        state_r <= temp_sensor_pkg::S_IDLE;
        sda_oe <= 1'b0;
      end else if (bus_start) begin
        state_r <= temp_sensor_pkg::S_ADDR;
        bitcnt_r <= 4'h0;
        byte_no_r <= 2'h0;
        gc_r <= 1'b0;
        ptr_rst_pend_r <= 1'b0;
        dev_ack_r <= 1'b0;
        sda_oe <= 1'b0;
      end else if (state_r != temp_sensor_pkg::S_IDLE && scl_rise) begin
        bitcnt_r <= (bitcnt_r == temp_sensor_pkg::BIT_ACK) ? 4'h0 : bitcnt_r + 4'h1;
        // Shift register is stable for a full serial period after this edge
        if (bitcnt_r == temp_sensor_pkg::BIT_LAST_DATA) begin
          rx_byte_r <= link_shift_r;
        end
        if (bitcnt_r == temp_sensor_pkg::BIT_ACK) begin
          dev_ack_r <= 1'b0;
          if (state_r == temp_sensor_pkg::S_READ && !dev_ack_r) begin
            rd_done_r <= 1'b1;
            if (sda_sy_r[1]) begin
              state_r <= temp_sensor_pkg::S_IGNORE;
            end else begin
              // Second byte comes from the LSB after a pair MSB, else from the same register; later ones repeat it
              tx_byte_r <= reg_byte(is_pair_msb(ptr_r) ? ptr_r + 8'h01 : ptr_r);
            end
          end
        end
      end else if (state_r != temp_sensor_pkg::S_IDLE && scl_fall) begin
        case (state_r)
          temp_sensor_pkg::S_ADDR: begin
            if (bitcnt_r == temp_sensor_pkg::BIT_ACK) begin
              if (!dev_busy && rx_byte_r[7:1] == own_addr) begin
                sda_oe <= 1'b1;
                dev_ack_r <= 1'b1;
                if (rx_byte_r[0]) begin
                  state_r <= temp_sensor_pkg::S_READ;
                  tx_byte_r <= reg_byte(ptr_r);
                end else begin
                  state_r <= temp_sensor_pkg::S_WRITE;
                end
              end else if (!dev_busy && rx_byte_r == {temp_sensor_pkg::GC_ADDR, 1'b0}) begin
                sda_oe <= 1'b1;
                dev_ack_r <= 1'b1;
                gc_r <= 1'b1;
                state_r <= temp_sensor_pkg::S_WRITE;
              end else begin
                state_r <= temp_sensor_pkg::S_IGNORE;
              end
            end
          end
          temp_sensor_pkg::S_WRITE: begin
            if (bitcnt_r == temp_sensor_pkg::BIT_ACK) begin
              if (gc_r) begin
                if (rx_byte_r == temp_sensor_pkg::GC_RESET_CMD) begin
                  sda_oe <= 1'b1;
                  gc_rst_pend_r <= 1'b1;
                end else begin
                  state_r <= temp_sensor_pkg::S_IGNORE;
                end
              end else begin
                sda_oe <= 1'b1;
                if (byte_no_r == 2'h0) begin
                  ptr_r <= rx_byte_r;
                  ptr_rst_pend_r <= (rx_byte_r == temp_sensor_pkg::PTR_RESET_CMD);
                  byte_no_r <= 2'h1;
                end else begin
                  ptr_rst_pend_r <= 1'b0;
                  // Data beyond the addressed register or pair is dropped
                  if (byte_no_r == 2'h1 || (byte_no_r == 2'h2 && is_pair_msb(ptr_r))) begin
                    wr_en_r <= 1'b1;
                    wr_addr_r <= wr_target;
                    wr_data_r <= rx_byte_r;
                    byte_no_r <= byte_no_r + 2'h1;
                  end
                end
              end
            end else if (bitcnt_r == 4'h0) begin
              sda_oe <= 1'b0;
              if (gc_rst_pend_r) begin
                soft_rst_r <= 1'b1;
              end
            end
          end
          temp_sensor_pkg::S_READ: begin
            // Low bit means pull the line, so enable is the inverted data
            if (bitcnt_r == temp_sensor_pkg::BIT_ACK) begin
              sda_oe <= 1'b0;
            end else begin
              sda_oe <= ~tx_byte_r[3'h7 - bitcnt_r[2:0]];
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limit comparison and alarm outputs

  logic signed [15:0] hyst_ext;
  logic signed [15:0] high_rel;
  logic signed [15:0] low_rel;
  logic signed [15:0] crit_rel;
  logic shut_prev_r;
  logic shut_entry;
  logic alarm_int_r;
  logic crit_int_r;
  temp_sensor_pkg::limit_flags_t flags_prev_r;
  logic alarm_active;
  logic crit_active;

  assign hyst_ext = signed'({5'h00, hyst_r, 7'h00});
  assign high_rel = signed'(high_r) - hyst_ext;
  assign low_rel = signed'(low_r) + hyst_ext;
  assign crit_rel = signed'(crit_r) - hyst_ext;
  assign shut_entry = (cfg_r.op_mode == temp_sensor_pkg::OP_SHUTDOWN) && !shut_prev_r;

  // Each flag sets past its limit and clears once back inside the margin
  always_ff @(posedge clk) begin
    if (init) begin
      flags_r <= '0;
    end else begin
      if (signed'(temp_r) > signed'(high_r)) begin
        flags_r.over <= 1'b1;
      end else if (signed'(temp_r) < high_rel) begin
        flags_r.over <= 1'b0;
      end
      if (signed'(temp_r) < signed'(low_r)) begin
        flags_r.under <= 1'b1;
      end else if (signed'(temp_r) > low_rel) begin
        flags_r.under <= 1'b0;
      end
      if (signed'(temp_r) > signed'(crit_r)) begin
        flags_r.crit <= 1'b1;
      end else if (signed'(temp_r) < crit_rel) begin
        flags_r.crit <= 1'b0;
      end
    end
  end

  // Interrupt mode latches fresh events; a new event wins over a clear
  always_ff @(posedge clk) begin
    if (init) begin
      flags_prev_r <= '0;
      shut_prev_r <= 1'b0;
      alarm_int_r <= 1'b0;
      crit_int_r <= 1'b0;
    end else begin
      flags_prev_r <= flags_r;
      shut_prev_r <= (cfg_r.op_mode == temp_sensor_pkg::OP_SHUTDOWN);
      if ((flags_r.over && !flags_prev_r.over) || (flags_r.under && !flags_prev_r.under)) begin
        alarm_int_r <= 1'b1;
      end else if (rd_done_r || shut_entry) begin
        alarm_int_r <= 1'b0;
      end
      if (flags_r.crit && !flags_prev_r.crit) begin
        crit_int_r <= 1'b1;
      end else if (rd_done_r || shut_entry) begin
        crit_int_r <= 1'b0;
      end
    end
  end

  // Comparator state follows the flags only, so shutdown leaves it alone
  assign alarm_active = (cfg_r.alarm_mode == temp_sensor_pkg::MODE_INTERRUPT) ? alarm_int_r
                        : (flags_r.over | flags_r.under);
  assign crit_active = (cfg_r.alarm_mode == temp_sensor_pkg::MODE_INTERRUPT) ? crit_int_r : flags_r.crit;

  // Open drain: enable pulls low, so active-high polarity pulls when idle
  always_ff @(posedge clk) begin
    if (srst) begin
      alarm_oe <= 1'b0;
      critical_output_oe <= 1'b0;
    end else begin
      alarm_oe <= alarm_active ^ (cfg_r.alarm_pol != temp_sensor_pkg::POL_ACTIVE_LOW);
      critical_output_oe <= crit_active ^ (cfg_r.crit_pol != temp_sensor_pkg::POL_ACTIVE_LOW);
    end
  end

endmodule // temp_sensor_i2c

// file: src/temp_sensor_pkg.sv
// What this block does
// - Byte-wide control registers, word-wide temperature registers
// - Two-byte read steps pointer MSB to LSB
// - No increment beyond one register pair
// - Pointer kept between transactions
// - Pointer 0x2f then stop resets defaults
// - No acknowledge while defaults reload
// - Acknowledge general call write address
// - General call 0x06 resets the device
// - Refuse other general call commands
// - Alarm on above high or below low
// - Interrupt mode default, comparator alternative
// - Comparator alarm clears with hysteresis margin
// - Shutdown keeps comparator alarm state
// - Any register read clears interrupt alarm
// - Interrupt alarm rearms on fresh event
// - Shutdown clears interrupt mode alarm
// - Continuous conversion after power-up
// - Hysteresis low nibble, whole degree steps
// - Bus address 10010 plus select pins
package temp_sensor_pkg;

  localparam logic [7:0] ADDR_TEMP_MSB = 8'h00;
  localparam logic [7:0] ADDR_TEMP_LSB = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_CONFIG = 8'h03;
  localparam logic [7:0] ADDR_HIGH_MSB = 8'h04;
  localparam logic [7:0] ADDR_HIGH_LSB = 8'h05;
  localparam logic [7:0] ADDR_LOW_MSB = 8'h06;
  localparam logic [7:0] ADDR_LOW_LSB = 8'h07;
  localparam logic [7:0] ADDR_CRIT_MSB = 8'h08;
  localparam logic [7:0] ADDR_CRIT_LSB = 8'h09;
  localparam logic [7:0] ADDR_HYST = 8'h0a;
  localparam logic [7:0] ADDR_ID = 8'h0b;
  localparam logic [7:0] PTR_RESET_CMD = 8'h2f;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;

  localparam logic [4:0] BUS_ADDR_FIXED = 5'h12;
  localparam logic [6:0] GC_ADDR = 7'h00;

  localparam logic [7:0] DEF_PTR = 8'h00;
  localparam logic [15:0] DEF_TEMP = 16'h0000;
  localparam logic [15:0] DEF_HIGH = 16'h2000;
  localparam logic [15:0] DEF_LOW = 16'h0500;
  localparam logic [15:0] DEF_CRIT = 16'h4000;
  localparam logic [3:0] DEF_HYST = 4'h5;
  localparam logic [7:0] DEF_CONFIG = 8'h00;
  // Arbitrary identification value
  localparam logic [7:0] ID_VALUE = 8'h5a;

  localparam logic [1:0] OP_SHUTDOWN = 2'h3;
  localparam logic MODE_INTERRUPT = 1'b0;
  localparam logic POL_ACTIVE_LOW = 1'b0;

  localparam int STAT_HIGH_BIT = 6;
  localparam int STAT_LOW_BIT = 5;
  localparam int STAT_CRIT_BIT = 4;
  localparam int HYST_SHIFT = 7;

  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  localparam int RESET_TIME_US = 200;
  localparam int CLK_FREQ_MHZ = 50;
  localparam int RESET_CYCLES = RESET_TIME_US * CLK_FREQ_MHZ;

  typedef struct packed {
    logic unused_hi;
    logic [1:0] op_mode;
    logic alarm_mode;
    logic alarm_pol;
    logic crit_pol;
    logic [1:0] unused_lo;
  } config_t;

  typedef struct packed {
    logic over;
    logic under;
    logic crit;
  } limit_flags_t;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_WRITE,
    S_READ,
    S_IGNORE
  } bus_state_t;

endpackage

// file: testbench/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // Clock stands high between frames; 80 ns bit period within them
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Long low phase: the target moves the data line up to three system clocks after the fall,
  // and a change that it made while the clock is high would read as start or stop
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    #60 scl = 1'b1;
    #18 r = sda;
    #2 scl = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(a, ack);
  endtask
  task automatic start();
    sda_low = 1'b0;
    #40 scl = 1'b1;
    #60 sda_low = 1'b1;
    #60 scl = 1'b0;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #40 scl = 1'b1;
    #60 sda_low = 1'b0;
    #100;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input int n, input logic [15:0] d,
                    output logic [3:0] acks);
    logic [7:0] q;
    acks = 4'hf;
    start();
    byte_io({a, 1'b0}, 1'b1, q, acks[3]);
    if (!acks[3]) byte_io(p, 1'b1, q, acks[2]);
    if (!acks[3] && n > 0) byte_io(d[15:8], 1'b1, q, acks[1]);
    if (!acks[3] && n > 1) byte_io(d[7:0], 1'b1, q, acks[0]);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input int n, output logic [15:0] d, output logic ack);
    logic [7:0] q;
    logic x;
    d = 16'h0000;
    start();
    byte_io({a, 1'b1}, 1'b1, q, ack);
    if (!ack) byte_io(8'hff, n < 2, d[15:8], x);
    if (!ack && n > 1) byte_io(8'hff, 1'b1, d[7:0], x);
    stop();
  endtask
endmodule // i2c_host_model

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int RESET_CYC = 200;
  localparam logic [6:0] DEV = {temp_sensor_pkg::BUS_ADDR_FIXED, 2'b10};
  logic clk, srst, scl, host_low, sda, sda_out, sda_oe, sel0, sel1, valid, alarm_oe, crit_oe, ack;
  logic [15:0] temp, rdat;
  logic [3:0] acks;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  // Pull-up on the shared data line
  assign sda = (sda_oe ? sda_out : 1'b1) & ~host_low;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  i2c_host_model host (.scl(scl), .sda_low(host_low), .sda(sda));
  temp_sensor_i2c #(.RESET_CYCLES(RESET_CYC)) dut (.clk(clk), .srst(srst), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_bit0(sel0), .addr_select_bit1(sel1),
    .temp_sample(temp), .temp_sample_valid(valid), .alarm_oe(alarm_oe), .critical_output_oe(crit_oe));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (num_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic pin(input logic seen, input logic exp);
    check({15'h0, seen}, {15'h0, exp});
  endtask
  // Output update takes four cycles after the valid flag, so eight is ample
  task automatic sample(input logic [15:0] t);
    @(negedge clk);
    temp = t;
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic wreg(input logic [7:0] p, input int n, input logic [15:0] d);
    host.wr(DEV, p, n, d, acks);
    check({12'h0, acks}, {12'h0, 4'hf >> (n + 2)});
  endtask
  task automatic rreg(input int n, input logic [15:0] exp);
    host.rd(DEV, n, rdat, ack);
    check(rdat, exp);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    temp = 16'h0000;
    valid = 1'b0;
    {sel1, sel0} = 2'b10;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    repeat (8) @(negedge clk);
    pin(alarm_oe, 1'b1);
    sample(16'h0400);
    sample(16'h4100);
    pin(crit_oe, 1'b1);
    sample(16'h1000);
    pin(alarm_oe, 1'b1);
    wreg(temp_sensor_pkg::ADDR_TEMP_MSB, 0, 16'h0000);
    rreg(2, 16'h1000);
    pin(alarm_oe, 1'b0);
    pin(crit_oe, 1'b0);
    wreg(temp_sensor_pkg::ADDR_ID, 0, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      {sel1, sel0} = 2'(i);
      host.rd({temp_sensor_pkg::BUS_ADDR_FIXED, 2'(i)}, 1, rdat, ack);
      pin(ack, 1'b0);
      check(rdat, {temp_sensor_pkg::ID_VALUE, 8'h00});
      host.rd({temp_sensor_pkg::BUS_ADDR_FIXED, 2'(i) ^ 2'h1}, 1, rdat, ack);
      pin(ack, 1'b1);
    end
    @(negedge clk);
    {sel1, sel0} = 2'b10;
    wreg(temp_sensor_pkg::ADDR_HIGH_MSB, 0, 16'h0000);
    rreg(2, temp_sensor_pkg::DEF_HIGH);
    rreg(1, {temp_sensor_pkg::DEF_HIGH[15:8], 8'h00});
    wreg(temp_sensor_pkg::ADDR_HIGH_LSB, 0, 16'h0000);
    rreg(2, {2{temp_sensor_pkg::DEF_HIGH[7:0]}});
    wreg(temp_sensor_pkg::ADDR_HYST, 0, 16'h0000);
    rreg(1, {4'h0, temp_sensor_pkg::DEF_HYST, 8'h00});
    wreg(temp_sensor_pkg::ADDR_CONFIG, 0, 16'h0000);
    rreg(1, {temp_sensor_pkg::DEF_CONFIG, 8'h00});
    sample(16'h2100);
    pin(alarm_oe, 1'b1);
    rreg(1, {temp_sensor_pkg::DEF_CONFIG, 8'h00});
    pin(alarm_oe, 1'b0);
    sample(16'h2200);
    pin(alarm_oe, 1'b0);
    sample(16'h1000);
    sample(16'h2100);
    pin(alarm_oe, 1'b1);
    // Comparator mode: read keeps the alarm, hysteresis margin clears it
    wreg(temp_sensor_pkg::ADDR_CONFIG, 1, 16'h1000);
    rreg(1, 16'h1000);
    pin(alarm_oe, 1'b1);
    sample(16'h1e00);
    pin(alarm_oe, 1'b1);
    wreg(temp_sensor_pkg::ADDR_CONFIG, 1, 16'h7000);
    sample(16'h1000);
    pin(alarm_oe, 1'b1);
    wreg(temp_sensor_pkg::ADDR_CONFIG, 1, 16'h1000);
    sample(16'h1c00);
    pin(alarm_oe, 1'b0);
    wreg(temp_sensor_pkg::ADDR_CONFIG, 1, 16'h0000);
    sample(16'h2100);
    pin(alarm_oe, 1'b1);
    wreg(temp_sensor_pkg::ADDR_CONFIG, 1, 16'h6000);
    pin(alarm_oe, 1'b0);
    wreg(temp_sensor_pkg::ADDR_CONFIG, 1, 16'h0800);
    sample(16'h1000);
    pin(alarm_oe, 1'b1);
    wreg(temp_sensor_pkg::PTR_RESET_CMD, 0, 16'h0000);
    host.wr(DEV, temp_sensor_pkg::ADDR_CONFIG, 0, 16'h0000, acks);
    pin(acks[3], 1'b1);
    repeat (RESET_CYC + 20) @(negedge clk);
    rreg(2, temp_sensor_pkg::DEF_TEMP);
    wreg(temp_sensor_pkg::ADDR_CONFIG, 0, 16'h0000);
    rreg(1, {temp_sensor_pkg::DEF_CONFIG, 8'h00});
    host.wr(temp_sensor_pkg::GC_ADDR, 8'h05, 0, 16'h0000, acks);
    check({12'h0, acks}, 16'h0007);
    wreg(temp_sensor_pkg::ADDR_HIGH_MSB, 2, 16'h3000);
    rreg(2, 16'h3000);
    host.wr(temp_sensor_pkg::GC_ADDR, temp_sensor_pkg::GC_RESET_CMD, 0, 16'h0000, acks);
    check({12'h0, acks}, 16'h0003);
    host.rd(DEV, 1, rdat, ack);
    pin(ack, 1'b1);
    repeat (RESET_CYC + 20) @(negedge clk);
    wreg(temp_sensor_pkg::ADDR_HIGH_MSB, 0, 16'h0000);
    rreg(2, temp_sensor_pkg::DEF_HIGH);
    end_of_test();
  end
endmodule // tb

// file: testbench/temp_sensor_i2c_properties.sv
`timescale 1ns/1ps
module temp_sensor_i2c_properties #(
  parameter int RESET_CYCLES = temp_sensor_pkg::RESET_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic [15:0] temp_sample,
  input wire logic temp_sample_valid,
  input wire logic alarm_oe,
  input wire logic critical_output_oe
);
  logic quiet_r;
  logic [15:0] last_r;
  // Register defaults are only known until the first bus frame
  always_ff @(posedge clk) begin
    if (srst) quiet_r <= 1'b1;
    else if (!scl) quiet_r <= 1'b0;
  end
  always_ff @(posedge clk) begin
    if (srst) last_r <= temp_sensor_pkg::DEF_TEMP;
    else if (temp_sample_valid) last_r <= temp_sample;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////
  sequence s_hot;
    quiet_r && temp_sample_valid && $signed(temp_sample) > $signed(temp_sensor_pkg::DEF_HIGH);
  endsequence
  sequence s_cold;
    quiet_r && temp_sample_valid && $signed(temp_sample) < $signed(temp_sensor_pkg::DEF_LOW);
  endsequence
  sequence s_burn;
    quiet_r && temp_sample_valid && $signed(temp_sample) > $signed(temp_sensor_pkg::DEF_CRIT);
  endsequence
  chk_reset_idle: assert property (disable iff (1'b0) srst |=> !sda_oe && !alarm_oe && !critical_output_oe)
    else $error("outputs active after reset");
  chk_alarm_over: assert property (s_hot |-> ##[1:5] alarm_oe)
    else $error("no alarm above high limit");
  chk_alarm_under: assert property (s_cold |-> ##[1:5] alarm_oe)
    else $error("no alarm below low limit");
  chk_crit_over: assert property (s_burn |-> ##[1:5] critical_output_oe)
    else $error("no critical output above limit");
  chk_alarm_cause: assert property ($rose(alarm_oe) && quiet_r |->
    $signed(last_r) > $signed(temp_sensor_pkg::DEF_HIGH) || $signed(last_r) < $signed(temp_sensor_pkg::DEF_LOW))
    else $error("alarm without out of range sample");
  chk_alarm_sticky: assert property (quiet_r && alarm_oe |=> alarm_oe || !quiet_r)
    else $error("interrupt alarm cleared without read");
  chk_quiet_no_ack: assert property (quiet_r |-> !sda_oe)
    else $error("data line driven with idle bus");
  chk_drive_after_fall: assert property ($changed(sda_oe) |->
    !$past(scl, 1) || !$past(scl, 2) || !$past(scl, 3) || !$past(scl, 4) || !$past(scl, 5))
    else $error("data line changed far from clock fall");
  chk_pin_low_only: assert property (!sda_out)
    else $error("open drain output driven high");
endmodule // temp_sensor_i2c_properties

bind temp_sensor_i2c temp_sensor_i2c_properties #(.RESET_CYCLES(RESET_CYCLES)) props (
  .clk(clk), .srst(srst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .addr_select_bit0(addr_select_bit0), .addr_select_bit1(addr_select_bit1), .temp_sample(temp_sample),
  .temp_sample_valid(temp_sample_valid), .alarm_oe(alarm_oe), .critical_output_oe(critical_output_oe));
